// file: core/trip_ctrl_pkg.sv
// Shared constants, types and register map of the trip and restart controller
package trip_ctrl_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int FREQ_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] DEF_OFF = 8'h04;
    localparam logic [7:0] SETPT_OFF = 8'h08;
    localparam logic [7:0] STAT_OFF = 8'h0C;
    localparam logic [7:0] FREQ_OFF = 8'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CLR_MODE_LSB = 0;
    localparam int RESTART_BIT = 2;
    localparam int MEMMODE_BIT = 3;
    localparam int ST_TRIP_BIT = 0;
    localparam int ST_RUN_BIT = 1;
    localparam int ST_EN_BIT = 2;
    localparam int ST_COAST_BIT = 3;

    // ----------------------------------------------------------------
    // Mode codes
    // ----------------------------------------------------------------
    localparam logic [1:0] CLR_RISE_STOP = 2'h0;
    localparam logic [1:0] CLR_FALL_STOP = 2'h1;
    localparam logic [1:0] CLR_RISE_KEEP = 2'h2;
    localparam logic RESTART_ZERO = 1'b0;
    localparam logic RESTART_MATCH = 1'b1;
    localparam logic MEM_CLEAR = 1'b0;
    localparam logic MEM_KEEP = 1'b1;

    // ----------------------------------------------------------------
    // Reset values and steps
    // ----------------------------------------------------------------
    localparam logic [1:0] CLR_MODE_RST = 2'h0;
    localparam logic RESTART_RST = 1'b0;
    localparam logic MEMMODE_RST = 1'b0;
    localparam logic [15:0] DEF_FREQ_RST = 16'h0000;
    localparam logic [15:0] UPDN_STEP = 16'h000A;
    localparam logic [15:0] RAMP_STEP = 16'h0001;
    localparam logic [15:0] FREQ_ZERO = 16'h0000;
    localparam logic [15:0] FREQ_MAX = 16'hFFFF;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int RAMP_TICK_NS = 1000;
    localparam int RAMP_TICK_CYC =
        (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Pin indices of the synchronised inputs
    // ----------------------------------------------------------------
    localparam int PIN_RUN = 0;
    localparam int PIN_CLR = 1;
    localparam int PIN_KEY = 2;
    localparam int PIN_UP = 3;
    localparam int PIN_DOWN = 4;
    localparam int PIN_N = 5;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT, ST_STOP, ST_RUN, ST_TRIP
    } drive_state_e;

    typedef struct packed {
        logic mem_mode;
        logic [15:0] default_freq;
        logic [15:0] setpoint;
    } nv_s;

    typedef struct packed {
        logic enable;
        logic coast;
        logic [15:0] freq;
    } drive_s;

endpackage : trip_ctrl_pkg

// file: core/pin_edge_sync.sv
// Two-flop synchroniser with edge detection for one input pin
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync
    import trip_ctrl_pkg::*;
(
    input wire logic core_clk_in,  // System clock
    input wire logic rst_in,       // Synchronous reset, high
    input wire logic pin_in,       // Raw pin level
    output logic level_out,        // Synchronised level
    output logic rise_out,         // One-cycle off-to-on pulse
    output logic fall_out          // One-cycle on-to-off pulse
);

    logic meta_reg;  // First stage, read only by second
    logic sync_reg;  // Second stage
    logic last_reg;  // Previous synchronised level
    logic meta_next;
    logic sync_next;
    logic last_next;

    // Next values of the chain
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    // Register the chain
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign level_out = sync_reg;
    assign rise_out = sync_reg & ~last_reg;
    assign fall_out = ~sync_reg & last_reg;

endmodule : pin_edge_sync
`default_nettype wire

// file: core/freq_ramp.sv
// Output frequency ramp with load for zero start or speed matching
`timescale 1ns/1ps
`default_nettype none
module freq_ramp
    import trip_ctrl_pkg::*;
(
    input wire logic core_clk_in,        // System clock
    input wire logic rst_in,             // Synchronous reset, high
    input wire logic load_in,            // Load start frequency
    input wire logic [15:0] load_val_in, // Value to load
    input wire logic [15:0] target_in,   // Ramp target
    output logic [15:0] freq_out         // Present output frequency
);

    logic [15:0] freq_reg;   // Ramp value
    logic [15:0] freq_next;
    logic [8:0] div_reg;     // Tick divider
    logic [8:0] div_next;
    logic tick;              // One-cycle ramp step enable

    assign tick = (div_reg == 9'(RAMP_TICK_CYC - 1));

    // Divider and ramp step
    always_comb begin
        div_next = tick ? 9'h000 : div_reg + 9'h001;
        freq_next = freq_reg;
        if (load_in) begin
            freq_next = load_val_in;
        end else if (tick && freq_reg < target_in) begin
            // Accelerate, never past target
            if (target_in - freq_reg < RAMP_STEP) begin
                freq_next = target_in;
            end else begin
                freq_next = freq_reg + RAMP_STEP;
            end
        end else if (tick && freq_reg > target_in) begin
            // Decelerate, never past target
            if (freq_reg - target_in < RAMP_STEP) begin
                freq_next = target_in;
            end else begin
                freq_next = freq_reg - RAMP_STEP;
            end
        end
    end

    // Register the ramp
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            freq_reg <= FREQ_ZERO;
            div_reg <= 9'h000;
        end else begin
            freq_reg <= freq_next;
            div_reg <= div_next;
        end
    end

    assign freq_out = freq_reg;

endmodule : freq_ramp
`default_nettype wire

// file: core/trip_reset_restart_control.sv
// Trip latch, trip clear, restart and setpoint memory of a motor drive
//
// Contract
// - Mode 00: clear on rise, stop running
// - Mode 01: clear on fall, stop running
// - Mode 02: clear on rise, run unaffected
// - Keypad key clears like the terminal
// - Trip switches motor output off at once
// - Trip while running lets motor coast
// - Restart mode 00 resumes from 0 Hz
// - Restart mode 01 matches coasting motor speed
// - Memory mode 00 uses default at power-up
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module trip_reset_restart_control
    import trip_ctrl_pkg::*;
(
    input wire logic core_clk_in,          // 250 MHz clock
    input wire logic rst_in,               // Synchronous reset, high
    input wire logic [7:0] reg_addr_in,    // Register byte address
    input wire logic [31:0] reg_wdata_in,  // Write data
    input wire logic reg_wr_in,            // Write strobe
    input wire logic reg_rd_in,            // Read strobe
    output logic [31:0] reg_rdata_out,     // Read data, cycle after
    input wire logic run_cmd_in,           // Run command pin
    input wire logic trip_clear_input_in,  // Trip clear terminal pin
    input wire logic stop_reset_key_in,    // Keypad stop/reset key
    input wire logic speed_step_up_in,     // Speed step up pin
    input wire logic speed_step_down_in,   // Speed step down pin
    input wire logic trip_event_in,        // Protection trip, pulse
    input wire logic [15:0] motor_speed_in, // Measured motor speed
    input wire nv_s nv_in,                 // Stored values at power-up
    output nv_s nv_save_out,               // Values to store
    output drive_s drive_out               // Motor output stage control
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_N-1:0] pins;   // Raw pins
    logic [PIN_N-1:0] lvl;    // Synchronised levels
    logic [PIN_N-1:0] rise;   // Rising edge pulses
    logic [PIN_N-1:0] fall;   // Falling edge pulses

    assign pins[PIN_RUN] = run_cmd_in;
    assign pins[PIN_CLR] = trip_clear_input_in;
    assign pins[PIN_KEY] = stop_reset_key_in;
    assign pins[PIN_UP] = speed_step_up_in;
    assign pins[PIN_DOWN] = speed_step_down_in;

    // One synchroniser per pin
    for (genvar g = 0; g < PIN_N; g++) begin : g_sync
        pin_edge_sync u_sync (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .pin_in(pins[g]),
            .level_out(lvl[g]),
            .rise_out(rise[g]),
            .fall_out(fall[g])
        );
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [1:0] trip_clear_mode_reg;       // Trip clear mode
    logic [1:0] trip_clear_mode_next;
    logic restart_mode_select_reg;         // Restart mode
    logic restart_mode_select_next;
    logic frequency_memory_mode_reg;       // Setpoint memory mode
    logic frequency_memory_mode_next;
    logic [15:0] default_freq_reg;         // Default frequency setting
    logic [15:0] default_freq_next;
    logic [15:0] setpoint_reg;             // Stepped speed setpoint
    logic [15:0] setpoint_next;

    // ----------------------------------------------------------------
    // Drive state
    // ----------------------------------------------------------------
    drive_state_e state_reg;  // Drive sequence state
    drive_state_e state_next;
    logic trip_reg;           // Latched trip
    logic trip_next;
    logic en_reg;             // Output stage enabled
    logic en_next;
    logic resume_reg;         // Next start follows a trip clear
    logic resume_next;
    logic ramp_load;          // Load ramp start value
    logic [15:0] ramp_val;    // Ramp start value
    logic [15:0] ramp_target; // Ramp target
    logic [15:0] freq;        // Ramp output
    logic clear_evt;          // Trip clear edge in active mode
    logic clear_stops;        // Clear mode also stops the drive
    logic wr_ctrl;            // Write to control register
    logic [31:0] rdata_reg;   // Read data
    logic [31:0] rdata_next;

    // Edge picked by the clear mode, terminal or key alike
    always_comb begin
        if (trip_clear_mode_reg == CLR_FALL_STOP) begin
            clear_evt = fall[PIN_CLR] | (fall[PIN_KEY] & trip_reg);
        end else begin
            clear_evt = rise[PIN_CLR] | (rise[PIN_KEY] & trip_reg);
        end
        clear_stops = (trip_clear_mode_reg != CLR_RISE_KEEP);
    end

    // Ramp start value after a trip clear
    always_comb begin
        if ((resume_reg || state_reg == ST_TRIP)
            && restart_mode_select_reg == RESTART_MATCH) begin
            ramp_val = motor_speed_in;
        end else begin
            ramp_val = FREQ_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // Drive sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        trip_next = trip_reg;
        en_next = en_reg;
        resume_next = resume_reg;
        ramp_load = 1'b0;
        if (state_reg != ST_INIT && trip_event_in) begin
            state_next = ST_TRIP;
            trip_next = 1'b1;
            en_next = 1'b0;
        end else begin
            case (state_reg)
                ST_INIT: begin
                    // Power-up load done, wait for run
                    state_next = ST_STOP;
                end
                ST_STOP: begin
                    // Output off once ramped to zero
                    if (freq == FREQ_ZERO) begin
                        en_next = 1'b0;
                    end
                    if (rise[PIN_RUN]) begin
                        state_next = ST_RUN;
                        en_next = 1'b1;
                        ramp_load = 1'b1;
                        resume_next = 1'b0;
                    end
                end
                ST_RUN: begin
                    if (!lvl[PIN_RUN] || rise[PIN_KEY]) begin
                        // Run released or keypad stop
                        state_next = ST_STOP;
                    end else if (clear_evt && clear_stops) begin
                        state_next = ST_STOP;
                    end
                end
                ST_TRIP: begin
                    en_next = 1'b0;
                    if (clear_evt) begin
                        trip_next = 1'b0;
                        resume_next = 1'b1;
                        if (!clear_stops && lvl[PIN_RUN]) begin
                            state_next = ST_RUN;
                            en_next = 1'b1;
                            ramp_load = 1'b1;
                            resume_next = 1'b0;
                        end else begin
                            state_next = ST_STOP;
                        end
                    end
                end
                default: begin
                    state_next = ST_INIT;
                end
            endcase
        end
    end

    // Register the sequence
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_reg <= ST_INIT;
            trip_reg <= 1'b0;
            en_reg <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            trip_reg <= trip_next;
            en_reg <= en_next;
            resume_reg <= resume_next;
        end
    end

    // ----------------------------------------------------------------
    // Frequency ramp
    // ----------------------------------------------------------------
    assign ramp_target = (state_reg == ST_RUN) ? setpoint_reg : FREQ_ZERO;

    freq_ramp u_ramp (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .load_in(ramp_load),
        .load_val_in(ramp_val),
        .target_in(ramp_target),
        .freq_out(freq)
    );

    // ----------------------------------------------------------------
    // Configuration and setpoint
    // ----------------------------------------------------------------
    assign wr_ctrl = reg_wr_in && reg_addr_in == CTRL_OFF;

    always_comb begin
        trip_clear_mode_next = trip_clear_mode_reg;
        restart_mode_select_next = restart_mode_select_reg;
        frequency_memory_mode_next = frequency_memory_mode_reg;
        default_freq_next = default_freq_reg;
        setpoint_next = setpoint_reg;
        if (state_reg == ST_INIT) begin
            // Stored values captured after reset release
            frequency_memory_mode_next = nv_in.mem_mode;
            default_freq_next = nv_in.default_freq;
            if (nv_in.mem_mode == MEM_KEEP) begin
                setpoint_next = nv_in.setpoint;
            end else begin
                setpoint_next = nv_in.default_freq;
            end
        end else begin
            if (wr_ctrl) begin
                trip_clear_mode_next =
                    reg_wdata_in[CLR_MODE_LSB +: 2];
                restart_mode_select_next = reg_wdata_in[RESTART_BIT];
                frequency_memory_mode_next = reg_wdata_in[MEMMODE_BIT];
            end
            if (reg_wr_in && reg_addr_in == DEF_OFF) begin
                default_freq_next = reg_wdata_in[15:0];
            end
            if (reg_wr_in && reg_addr_in == SETPT_OFF) begin
                setpoint_next = reg_wdata_in[15:0];
            end else if (rise[PIN_UP] && !rise[PIN_DOWN]) begin
                // Step up, saturate at top
                if (FREQ_MAX - setpoint_reg < UPDN_STEP) begin
                    setpoint_next = FREQ_MAX;
                end else begin
                    setpoint_next = setpoint_reg + UPDN_STEP;
                end
            end else if (rise[PIN_DOWN] && !rise[PIN_UP]) begin
                // Step down, saturate at zero
                if (setpoint_reg < UPDN_STEP) begin
                    setpoint_next = FREQ_ZERO;
                end else begin
                    setpoint_next = setpoint_reg - UPDN_STEP;
                end
            end
        end
    end

    // Register configuration
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            trip_clear_mode_reg <= CLR_MODE_RST;
            restart_mode_select_reg <= RESTART_RST;
            frequency_memory_mode_reg <= MEMMODE_RST;
            default_freq_reg <= DEF_FREQ_RST;
            setpoint_reg <= FREQ_ZERO;
        end else begin
            trip_clear_mode_reg <= trip_clear_mode_next;
            restart_mode_select_reg <= restart_mode_select_next;
            frequency_memory_mode_reg <= frequency_memory_mode_next;
            default_freq_reg <= default_freq_next;
            setpoint_reg <= setpoint_next;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (!reg_rd_in) begin
            rdata_next = 32'h0000_0000;
        end else if (reg_addr_in == CTRL_OFF) begin
            rdata_next[CLR_MODE_LSB +: 2] = trip_clear_mode_reg;
            rdata_next[RESTART_BIT] = restart_mode_select_reg;
            rdata_next[MEMMODE_BIT] = frequency_memory_mode_reg;
        end else if (reg_addr_in == DEF_OFF) begin
            rdata_next[15:0] = default_freq_reg;
        end else if (reg_addr_in == SETPT_OFF) begin
            rdata_next[15:0] = setpoint_reg;
        end else if (reg_addr_in == STAT_OFF) begin
            rdata_next[ST_TRIP_BIT] = trip_reg;
            rdata_next[ST_RUN_BIT] = (state_reg == ST_RUN);
            rdata_next[ST_EN_BIT] = en_reg;
            rdata_next[ST_COAST_BIT] = trip_reg;
        end else if (reg_addr_in == FREQ_OFF) begin
            rdata_next[15:0] = freq;
        end
    end

    // Register read data
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out = rdata_reg;

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // trip cuts the enable in its own cycle
    assign drive_out.enable = en_reg & ~trip_event_in;
    assign drive_out.coast = trip_reg | trip_event_in;
    assign drive_out.freq = freq;
    assign nv_save_out.mem_mode = frequency_memory_mode_reg;
    assign nv_save_out.default_freq = default_freq_reg;
    assign nv_save_out.setpoint = setpoint_reg;

endmodule : trip_reset_restart_control
`default_nettype wire

// file: sim/trip_ctrl_monitor.sv
// Checker of trip latch, output cut and register reads
`timescale 1ns/1ps
`default_nettype none
module trip_ctrl_monitor
    import trip_ctrl_pkg::*;
(
    input wire logic core_clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic [7:0] reg_addr_in, // Address
    input wire logic reg_rd_in, // Read strobe
    input wire logic [31:0] reg_rdata_out, // Read data
    input wire logic trip_clear_input_in, // Clear pin
    input wire logic stop_reset_key_in, // Key pin
    input wire logic trip_event_in, // Trip
    input wire nv_s nv_in, // Stored values
    input wire nv_s nv_save_out, // Values to store
    input wire drive_s drive_out // Output stage
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    trip_off_a: assert property (trip_event_in |-> !drive_out.enable)
        else $error("output on during trip");
    coast_on_a: assert property (trip_event_in |=> drive_out.coast)
        else $error("no coast after trip");
    trip_dis_a: assert property (drive_out.coast |-> !drive_out.enable)
        else $error("output on while tripped");
    // Quiet clear pins cannot release a latched trip
    trip_hold_a: assert property ((drive_out.coast
        && $stable(trip_clear_input_in) && $stable(stop_reset_key_in))[*5]
        |=> drive_out.coast) else $error("trip released silently");
    // Power-up setpoint follows the memory mode
    powerup_sp_a: assert property ($fell(rst_in) |-> ##2
        nv_save_out.setpoint == (nv_in.mem_mode ? nv_in.setpoint
        : nv_in.default_freq)) else $error("wrong power-up setpoint");
    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 0)
        else $error("read data outside read slot");
    rd_unmapped_a: assert property (reg_rd_in && reg_addr_in[7:2] > 6'h04
        |=> reg_rdata_out == 0) else $error("unmapped read not zero");
    ctrl_upper_a: assert property (reg_rd_in && reg_addr_in == CTRL_OFF
        |=> reg_rdata_out[31:4] == 0) else $error("control upper bits set");
    // Main scenarios
    cover property ($fell(drive_out.coast));
    cover property ($rose(drive_out.enable));
    cover property (reg_rd_in && reg_addr_in == STAT_OFF);
endmodule : trip_ctrl_monitor
`default_nettype wire

// file: sim/trip_panel_model.sv
// Keypad, input terminals and coasting motor seen by the drive
`timescale 1ns/1ps
`default_nettype none
module trip_panel_model
    import trip_ctrl_pkg::*;
#(
    parameter logic [15:0] COAST_SPEED = 16'h0064 // Motor speed
)
(
    input wire logic core_clk_in, // Clock
    input wire logic [PIN_N-1:0] req_in, // Requested levels
    output logic [PIN_N-1:0] pin_out, // Pin levels
    output logic [15:0] motor_speed_out // Coasting speed
);
    // Pins move just after an edge, like switch contacts
    always @(posedge core_clk_in) begin
        pin_out <= req_in;
    end
    // A coasting motor keeps its speed while the output is cut
    assign motor_speed_out = COAST_SPEED;
endmodule : trip_panel_model
`default_nettype wire

// file: sim/trip_reset_restart_control_bench.sv
// Self-checking bench of trip clear, restart and setpoint memory
`timescale 1ns/1ps
`default_nettype none
module trip_reset_restart_control_bench
    import trip_ctrl_pkg::*;
;
    logic clk = 1'b0; // Core clock
    logic rst = 1'b1; // Reset
    logic [7:0] addr = 8'h00; // Bus address
    logic [31:0] wdata = 32'h0000_0000; // Bus write data
    logic wr = 1'b0; // Write strobe
    logic rd = 1'b0; // Read strobe
    logic trip = 1'b0; // Protection trip
    logic [PIN_N-1:0] req = '0; // Wanted pin levels
    nv_s nv = '0; // Stored values
    logic [31:0] rdata; // Read data
    logic [PIN_N-1:0] pins; // Pin levels
    logic [15:0] speed; // Motor speed
    nv_s nv_save; // Values to store
    drive_s drive; // Output stage
    int miscompares = 0; // Mismatches
    int num_checks = 0; // Comparisons
    logic [31:0] v; // Read result
    // Clock of 4 ns
    always #2 clk = ~clk;
    trip_panel_model model_u (.core_clk_in(clk), .req_in(req),
        .pin_out(pins), .motor_speed_out(speed));
    trip_reset_restart_control dut_u (.core_clk_in(clk), .rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .run_cmd_in(pins[PIN_RUN]), .trip_clear_input_in(pins[PIN_CLR]),
        .stop_reset_key_in(pins[PIN_KEY]), .speed_step_up_in(pins[PIN_UP]),
        .speed_step_down_in(pins[PIN_DOWN]), .trip_event_in(trip),
        .motor_speed_in(speed), .nv_in(nv), .nv_save_out(nv_save),
        .drive_out(drive));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("Checks %0d, errors %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Data stand only in the cycle after the read edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic pin(input int idx, input logic val);
        @(posedge clk);
        req[idx] <= val;
        repeat (8) @(posedge clk);
    endtask : pin
    task automatic wait_en(input logic e);
        int n;
        n = 0;
        while (drive.enable !== e && n < 30000) begin
            @(posedge clk);
            #1 n++;
        end
        chk({31'h0000_0000, drive.enable}, {31'h0000_0000, e});
    endtask : wait_en
    task automatic do_reset(input logic mem);
        @(posedge clk);
        rst <= 1'b1;
        nv <= '{mem, 16'h0064, 16'h0032};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : do_reset
    // Trip while running, then clear it from terminal or key
    task automatic trip_case(input int mode, input int src);
        int p;
        p = src ? PIN_KEY : PIN_CLR;
        wr_reg(CTRL_OFF, mode | (src << RESTART_BIT));
        rd_reg(CTRL_OFF, v);
        chk(v, mode | (src << RESTART_BIT));
        pin(PIN_RUN, 1'b0);
        wait_en(1'b0);
        pin(PIN_RUN, 1'b1);
        wait_en(1'b1);
        if (mode == 2) begin
            pin(PIN_CLR, 1'b1);
            rd_reg(STAT_OFF, v);
            chk(v & 32'h0000_0003, 32'h0000_0002);
            pin(PIN_CLR, 1'b0);
        end
        @(posedge clk);
        trip <= 1'b1;
        @(posedge clk);
        trip <= 1'b0;
        rd_reg(STAT_OFF, v);
        chk(v & 32'h0000_000D, 32'h0000_0009);
        pin(p, 1'b1);
        if (mode == 1) begin
            rd_reg(STAT_OFF, v);
            chk(v & 32'h0000_0001, 32'h0000_0001);
            pin(p, 1'b0);
        end
        rd_reg(STAT_OFF, v);
        chk(v & 32'h0000_0003, mode == 2 ? 2 : 0);
        if (mode == 2) begin
            rd_reg(FREQ_OFF, v);
            chk(src ? v : v >> 1, src ? 32'h0000_0064 : 0);
        end
        pin(p, 1'b0);
    endtask : trip_case
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int m = 1; m >= 0; m--) begin
            do_reset(m[0]);
            rd_reg(SETPT_OFF, v);
            chk(v, m ? 32'h0000_0032 : 32'h0000_0064);
        end
        rd_reg(8'h20, v);
        chk(v, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            trip_case(i % 3, i / 3);
        end
        pin(PIN_UP, 1'b1);
        pin(PIN_UP, 1'b0);
        chk({16'h0000, nv_save.setpoint}, 32'h0000_006E);
        pin(PIN_DOWN, 1'b1);
        pin(PIN_DOWN, 1'b0);
        chk({16'h0000, nv_save.setpoint}, 32'h0000_0064);
        finish_test();
    end
    // Watchdog against a hang
    initial begin
        #400000;
        miscompares++;
        finish_test();
    end
endmodule : trip_reset_restart_control_bench
bind trip_reset_restart_control trip_ctrl_monitor mon_u (.*);
`default_nettype wire
